/* src/dcr_byte_ptr.sv */
// Byte pointer that steps once per byte and wraps at a programmed size.
// Assumes step and clear come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module dcr_byte_ptr #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic clear,
  input wire logic step,
  input wire logic [W-1:0] limit,
  // Pointer
  output logic [W-1:0] ptr
);
  logic [W-1:0] next_ptr;

  // Next position; a size of zero lets the pointer run freely
  assign next_ptr = ptr + {{(W-1){1'b0}}, 1'b1};

  // Clear beats step so a match never leaves a stale count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr <= '0;
    end else if (clear) begin
      ptr <= '0;
    end else if (step) begin
      ptr <= (next_ptr == limit) ? '0 : next_ptr;
    end
  end
endmodule
`default_nettype wire

/* src/dcr_chan_regs.sv */
// One channel's address, size and pointer registers behind an APB slave.
// Assumes the transfer engine pulses byte strobes on the same clock.
//
// Overview of operation
// - Full 32-bit read/write source start address register.
// - Full 32-bit read/write destination start address, zero at reset.
// - Source size is a 16-bit byte count; all ones means 65,535.
// - Upper sixteen bits of both size registers read zero, ignore writes.
// - In pattern mode a detected match clears the source pointer.
// - Block done raises after the larger size moves, or on a match.
// - Destination half flag raises when its pointer reaches half the size.
`timescale 1ns/100ps
`default_nettype none
module dcr_chan_regs #(
  parameter int AW = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transfer engine strobes
  input wire logic src_byte_rd,
  input wire logic dst_byte_wr,
  input wire logic pattern_match,
  // Values for the transfer engine
  output logic [31:0] src_start_addr,
  output logic [31:0] dst_start_addr,
  output logic [15:0] src_size_bytes,
  output logic [15:0] dst_size_bytes,
  output logic [15:0] src_progress_ptr,
  output logic [15:0] dst_progress_ptr,
  output logic chan_enable,
  output logic pattern_mode,
  // Events
  output logic block_done_flag,
  output logic dst_half_full_flag,
  output logic irq
);
  logic [3:0] wr_idx;
  logic wr_go;
  logic [31:0] wr_data32;
  logic [15:0] max_size;
  logic [15:0] xfer_cnt;
  logic [15:0] next_xfer;
  logic [15:0] next_dptr;
  logic [15:0] half_size;
  logic src_step;
  logic dst_step;
  logic match_hit;
  logic done_evt;
  logic half_evt;
  logic src_clear;
  logic [4:0] int_stat;
  logic [4:0] int_en;
  logic [4:0] int_set;
  logic [4:0] int_clr;

  // Map a byte address onto a register index
  function automatic logic [3:0] reg_index(input logic [AW-1:0] a);
    logic [11:0] a12;
    a12 = 12'(a);
    unique case (a12)
      dcr_pkg::OFF_SRC_START: reg_index = dcr_pkg::IDX_SRC_START;
      dcr_pkg::OFF_DST_START: reg_index = dcr_pkg::IDX_DST_START;
      dcr_pkg::OFF_SRC_SIZE: reg_index = dcr_pkg::IDX_SRC_SIZE;
      dcr_pkg::OFF_DST_SIZE: reg_index = dcr_pkg::IDX_DST_SIZE;
      dcr_pkg::OFF_SRC_PTR: reg_index = dcr_pkg::IDX_SRC_PTR;
      dcr_pkg::OFF_DST_PTR: reg_index = dcr_pkg::IDX_DST_PTR;
      dcr_pkg::OFF_CTRL: reg_index = dcr_pkg::IDX_CTRL;
      dcr_pkg::OFF_INT_STAT: reg_index = dcr_pkg::IDX_INT_STAT;
      dcr_pkg::OFF_INT_CLR: reg_index = dcr_pkg::IDX_INT_CLR;
      dcr_pkg::OFF_INT_EN: reg_index = dcr_pkg::IDX_INT_EN;
      default: reg_index = dcr_pkg::IDX_NONE;
    endcase
  endfunction

  // Merge write data into an old word under the byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  // Zero-wait slave; an unmapped address errors at the access phase
  assign pready = 1'b1;
  assign pslverr = psel && penable && (reg_index(paddr) == dcr_pkg::IDX_NONE);
  assign wr_idx = reg_index(paddr);
  assign wr_go = psel && penable && pwrite;
  assign wr_data32 = pwdata;

  // Start addresses take every bit written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_start_addr <= dcr_pkg::RST_ADDR;
      dst_start_addr <= dcr_pkg::RST_ADDR;
    end else if (wr_go) begin
      if (wr_idx == dcr_pkg::IDX_SRC_START) begin
        src_start_addr <= merge(src_start_addr, wr_data32, pstrb);
      end
      if (wr_idx == dcr_pkg::IDX_DST_START) begin
        dst_start_addr <= merge(dst_start_addr, wr_data32, pstrb);
      end
    end
  end

  // Only the low half is stored; upper strobes fall away
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_size_bytes <= dcr_pkg::RST_SIZE;
      dst_size_bytes <= dcr_pkg::RST_SIZE;
    end else if (wr_go) begin
      if (wr_idx == dcr_pkg::IDX_SRC_SIZE) begin
        src_size_bytes <= 16'(merge({16'h0000, src_size_bytes},
                                    wr_data32, pstrb));
      end
      if (wr_idx == dcr_pkg::IDX_DST_SIZE) begin
        dst_size_bytes <= 16'(merge({16'h0000, dst_size_bytes},
                                    wr_data32, pstrb));
      end
    end
  end

  // Software write of enable wins over the hardware stop at block end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {pattern_mode, chan_enable} <= dcr_pkg::RST_CTRL;
    end else if (wr_go && wr_idx == dcr_pkg::IDX_CTRL && pstrb[0]) begin
      chan_enable <= pwdata[dcr_pkg::CTRL_EN_BIT];
      pattern_mode <= pwdata[dcr_pkg::CTRL_PAT_BIT];
    end else if (done_evt) begin
      chan_enable <= 1'b0;
    end
  end

  // Engine strobes count only while the channel runs
  assign src_step = chan_enable && src_byte_rd;
  assign dst_step = chan_enable && dst_byte_wr;
  assign match_hit = chan_enable && pattern_mode && pattern_match;
  assign src_clear = match_hit || done_evt;

  // Source pointer; a pattern match resets it
  dcr_byte_ptr #(.W(dcr_pkg::SIZE_W)) u_src_ptr (
    .pclk(pclk),
    .presetn(presetn),
    .clear(src_clear),
    .step(src_step),
    .limit(src_size_bytes),
    .ptr(src_progress_ptr)
  );

  // Destination pointer wraps at its own size
  dcr_byte_ptr #(.W(dcr_pkg::SIZE_W)) u_dst_ptr (
    .pclk(pclk),
    .presetn(presetn),
    .clear(done_evt),
    .step(dst_step),
    .limit(dst_size_bytes),
    .ptr(dst_progress_ptr)
  );

  // Block length is the larger of the two sizes
  assign max_size = (src_size_bytes > dst_size_bytes) ?
                    src_size_bytes : dst_size_bytes;
  assign next_xfer = xfer_cnt + 16'h0001;
  assign done_evt = match_hit ||
                    (dst_step && max_size != 16'h0000 &&
                     next_xfer == max_size);

  // Bytes moved in this block, counted at the destination side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_cnt <= dcr_pkg::RST_PTR;
    end else if (done_evt) begin
      xfer_cnt <= dcr_pkg::RST_PTR;
    end else if (dst_step) begin
      xfer_cnt <= next_xfer;
    end
  end

  // Midpoint hit on the step that lands the pointer there
  assign half_size = dst_size_bytes >> 1;
  assign next_dptr = dst_progress_ptr + 16'h0001;
  assign half_evt = dst_step && half_size != 16'h0000 &&
                    next_dptr == half_size;

  // Sticky status; a set in the clear cycle survives
  always_comb begin
    int_set = dcr_pkg::RST_INT;
    int_set[dcr_pkg::INT_BLOCK_DONE_BIT] = done_evt;
    int_set[dcr_pkg::INT_DST_HALF_BIT] = half_evt;
    int_clr = (wr_go && wr_idx == dcr_pkg::IDX_INT_CLR) ?
              5'(pwdata) : dcr_pkg::RST_INT;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= dcr_pkg::RST_INT;
    end else begin
      int_stat <= (int_stat & ~int_clr) | int_set;
    end
  end

  // Interrupt enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_en <= dcr_pkg::RST_INT;
    end else if (wr_go && wr_idx == dcr_pkg::IDX_INT_EN && pstrb[0]) begin
      int_en <= 5'(pwdata);
    end
  end

  assign block_done_flag = int_stat[dcr_pkg::INT_BLOCK_DONE_BIT];
  assign dst_half_full_flag = int_stat[dcr_pkg::INT_DST_HALF_BIT];
  assign irq = |(int_stat & int_en);

  // Read data is latched in the setup cycle so it stands in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (reg_index(paddr))
        dcr_pkg::IDX_SRC_START: prdata <= src_start_addr;
        dcr_pkg::IDX_DST_START: prdata <= dst_start_addr;
        dcr_pkg::IDX_SRC_SIZE: prdata <= {16'h0000, src_size_bytes};
        dcr_pkg::IDX_DST_SIZE: prdata <= {16'h0000, dst_size_bytes};
        dcr_pkg::IDX_SRC_PTR: prdata <= {16'h0000, src_progress_ptr};
        dcr_pkg::IDX_DST_PTR: prdata <= {16'h0000, dst_progress_ptr};
        dcr_pkg::IDX_CTRL: prdata <= {30'h0, pattern_mode, chan_enable};
        dcr_pkg::IDX_INT_STAT: prdata <= {27'h0, int_stat};
        dcr_pkg::IDX_INT_EN: prdata <= {27'h0, int_en};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Checks on register and pointer behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ssa_write_a: assert property (
    wr_go && wr_idx == dcr_pkg::IDX_SRC_START && pstrb == 4'hF
    |=> src_start_addr == $past(pwdata))
    else $error("source start not stored");

  dsa_write_a: assert property (
    wr_go && wr_idx == dcr_pkg::IDX_DST_START && pstrb == 4'hF
    |=> dst_start_addr == $past(pwdata) [*1] ##1
        (dst_start_addr == $past(dst_start_addr) || $past(wr_go)))
    else $error("destination start not held");

  ssiz_write_a: assert property (
    wr_go && wr_idx == dcr_pkg::IDX_SRC_SIZE && pstrb == 4'hF
    |=> src_size_bytes == $past(pwdata[15:0]))
    else $error("source size not stored");

  size_upper_a: assert property (
    psel && !penable && !pwrite &&
    (reg_index(paddr) == dcr_pkg::IDX_SRC_SIZE ||
     reg_index(paddr) == dcr_pkg::IDX_DST_SIZE)
    |=> prdata[31:16] == 16'h0000 &&
        prdata[15:0] == $past(reg_index(paddr) == dcr_pkg::IDX_SRC_SIZE ?
                              src_size_bytes : dst_size_bytes))
    else $error("size readback wrong");

  sptr_step_a: assert property (
    src_step && !src_clear && 16'(src_progress_ptr + 16'h0001) !=
    src_size_bytes |=> src_progress_ptr == $past(src_progress_ptr) + 16'h0001)
    else $error("source pointer did not step");

  sptr_hold_a: assert property (
    !src_step && !src_clear |=> $stable(src_progress_ptr))
    else $error("source pointer moved without a byte");

  pat_clear_a: assert property (
    chan_enable && pattern_mode && pattern_match
    |=> src_progress_ptr == 16'h0000 && block_done_flag)
    else $error("pattern match did not clear pointer");

  done_set_a: assert property (
    dst_step && max_size != 16'h0000 && xfer_cnt == max_size - 16'h0001
    |=> block_done_flag && !chan_enable ||
        $past(wr_go && wr_idx == dcr_pkg::IDX_CTRL))
    else $error("block done not raised at larger size");

  half_set_a: assert property (
    dst_step && half_size != 16'h0000 &&
    dst_progress_ptr == half_size - 16'h0001
    |=> dst_half_full_flag ##1 dst_half_full_flag || $past(wr_go))
    else $error("half flag not raised at midpoint");

  // Main scenarios
  blk_done_c: cover property (dst_step ##1 block_done_flag && irq);
  half_c: cover property ($rose(dst_half_full_flag));
  pat_c: cover property (match_hit ##1 src_progress_ptr == 16'h0000);
  err_c: cover property (pslverr);
endmodule
`default_nettype wire

/* src/dcr_pkg.sv */
// Constants shared by the channel address and size register block.
// Assumes an APB master with 32-bit data and byte addressing.
package dcr_pkg;
  // Register byte offsets
  localparam logic [11:0] OFF_SRC_START = 12'h000;
  localparam logic [11:0] OFF_DST_START = 12'h004;
  localparam logic [11:0] OFF_SRC_SIZE = 12'h008;
  localparam logic [11:0] OFF_DST_SIZE = 12'h00C;
  localparam logic [11:0] OFF_SRC_PTR = 12'h010;
  localparam logic [11:0] OFF_DST_PTR = 12'h014;
  localparam logic [11:0] OFF_CTRL = 12'h018;
  localparam logic [11:0] OFF_INT_STAT = 12'h01C;
  localparam logic [11:0] OFF_INT_CLR = 12'h020;
  localparam logic [11:0] OFF_INT_EN = 12'h024;
  // Register index codes from the address decoder
  localparam logic [3:0] IDX_SRC_START = 4'h0;
  localparam logic [3:0] IDX_DST_START = 4'h1;
  localparam logic [3:0] IDX_SRC_SIZE = 4'h2;
  localparam logic [3:0] IDX_DST_SIZE = 4'h3;
  localparam logic [3:0] IDX_SRC_PTR = 4'h4;
  localparam logic [3:0] IDX_DST_PTR = 4'h5;
  localparam logic [3:0] IDX_CTRL = 4'h6;
  localparam logic [3:0] IDX_INT_STAT = 4'h7;
  localparam logic [3:0] IDX_INT_CLR = 4'h8;
  localparam logic [3:0] IDX_INT_EN = 4'h9;
  localparam logic [3:0] IDX_NONE = 4'hF;
  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PAT_BIT = 1;
  localparam int INT_BLOCK_DONE_BIT = 3;
  localparam int INT_DST_HALF_BIT = 4;
  localparam int SIZE_W = 16;
  // Reset values
  localparam logic [31:0] RST_ADDR = 32'h0000_0000;
  localparam logic [15:0] RST_SIZE = 16'h0000;
  localparam logic [15:0] RST_PTR = 16'h0000;
  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam logic [4:0] RST_INT = 5'h00;
endpackage

/* test/dcr_chan_regs_test.sv */
// Self-checking bench for the channel register block over APB.
// Assumes zero-wait APB and the engine stand-in for byte strobes.
`timescale 1ns/100ps
`default_nettype none
module dcr_chan_regs_test;
  logic pclk, presetn, psel, penable, pwrite, go, slow, match_go;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rq, src_start_addr, dst_start_addr;
  logic [7:0] n_bytes;
  logic [3:0] pstrb;
  logic pready, pslverr, rerr, src_byte_rd, dst_byte_wr, pattern_match;
  logic busy, chan_enable, pattern_mode, block_done_flag;
  logic dst_half_full_flag, irq;
  logic [15:0] src_size_bytes, dst_size_bytes, src_ptr, dst_ptr;
  int n_mismatch, samples_checked;
  dcr_chan_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_byte_rd(src_byte_rd), .dst_byte_wr(dst_byte_wr),
    .pattern_match(pattern_match), .src_start_addr(src_start_addr),
    .dst_start_addr(dst_start_addr), .src_size_bytes(src_size_bytes),
    .dst_size_bytes(dst_size_bytes), .src_progress_ptr(src_ptr),
    .dst_progress_ptr(dst_ptr), .chan_enable(chan_enable),
    .pattern_mode(pattern_mode), .block_done_flag(block_done_flag),
    .dst_half_full_flag(dst_half_full_flag), .irq(irq));
  dcr_engine_model i_eng (.pclk(pclk), .presetn(presetn), .go(go),
    .n_bytes(n_bytes), .slow(slow), .match_go(match_go),
    .src_byte_rd(src_byte_rd), .dst_byte_wr(dst_byte_wr),
    .pattern_match(pattern_match), .busy(busy));
  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; an idle edge after it keeps drivers single-step
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      end_sim();
    end
    rq = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rq, exp);
  endtask
  // Waits are bounded; flags land one cycle after the last strobe
  task automatic run(input logic [7:0] n, input logic s);
    int i;
    n_bytes <= n;
    slow <= s;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    for (i = 0; i < 100; i++) begin
      @(posedge pclk);
      if (busy === 1'b0) break;
    end
    if (i == 100) begin
      n_mismatch++;
      end_sim();
    end
    repeat (3) @(posedge pclk);
  endtask
  task automatic match;
    match_go <= 1'b1;
    @(posedge pclk);
    match_go <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  initial begin
    int i;
    presetn = 1'b0;
    {psel, penable, pwrite, go, slow, match_go} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    n_bytes = 8'h00;
    pstrb = 4'hF;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Every register clears at reset
    for (i = 0; i < 10; i++) begin
      rd(12'(i * 4), 32'h0000_0000);
    end
    $display("reset values done");
    // Physical bus addresses, all 32 bits held
    wr(dcr_pkg::OFF_SRC_START, 32'h8000_1234);
    rd(dcr_pkg::OFF_SRC_START, 32'h8000_1234);
    wr(dcr_pkg::OFF_DST_START, 32'hA5C3_0FF1);
    rd(dcr_pkg::OFF_DST_START, 32'hA5C3_0FF1);
    chk(src_start_addr, 32'h8000_1234);
    chk(dst_start_addr, 32'hA5C3_0FF1);
    // Only the strobed low bytes change
    pstrb <= 4'h3;
    wr(dcr_pkg::OFF_SRC_START, 32'hFFFF_FFFF);
    pstrb <= 4'hF;
    rd(dcr_pkg::OFF_SRC_START, 32'h8000_FFFF);
    wr(dcr_pkg::OFF_SRC_SIZE, 32'hFFFF_FFFF);
    rd(dcr_pkg::OFF_SRC_SIZE, 32'h0000_FFFF);
    chk({16'h0000, src_size_bytes}, 32'h0000_FFFF);
    wr(dcr_pkg::OFF_DST_SIZE, 32'h1234_5678);
    rd(dcr_pkg::OFF_DST_SIZE, 32'h0000_5678);
    wr(dcr_pkg::OFF_SRC_PTR, 32'h0000_0055);
    rd(dcr_pkg::OFF_SRC_PTR, 32'h0000_0000);
    bus(1'b0, 12'h030, 32'h0000_0000);
    chk(rq, 32'h0000_0000);
    chk({31'h0, rerr}, 32'h0000_0001);
    $display("register access done");
    // Block end after the larger size; irq masked and cleared
    // Destination size 2 puts its midpoint at 1, so the half flag rises too
    wr(dcr_pkg::OFF_SRC_SIZE, 32'h0000_0004);
    wr(dcr_pkg::OFF_DST_SIZE, 32'h0000_0002);
    wr(dcr_pkg::OFF_INT_EN, 32'h0000_0008);
    wr(dcr_pkg::OFF_CTRL, 32'h0000_0001);
    run(8'h03, 1'b0);
    rd(dcr_pkg::OFF_SRC_PTR, 32'h0000_0003);
    rd(dcr_pkg::OFF_DST_PTR, 32'h0000_0001);
    chk({31'h0, block_done_flag}, 32'h0000_0000);
    run(8'h01, 1'b0);
    chk({31'h0, block_done_flag}, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    chk({31'h0, chan_enable}, 32'h0000_0000);
    rd(dcr_pkg::OFF_INT_STAT, 32'h0000_0018);
    wr(dcr_pkg::OFF_INT_EN, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(dcr_pkg::OFF_INT_EN, 32'h0000_0008);
    wr(dcr_pkg::OFF_INT_CLR, 32'h0000_0018);
    chk({31'h0, irq}, 32'h0000_0000);
    rd(dcr_pkg::OFF_INT_STAT, 32'h0000_0000);
    $display("block end done");
    // Half flag at dst pointer 2 of 4, engine slow
    wr(dcr_pkg::OFF_DST_SIZE, 32'h0000_0004);
    wr(dcr_pkg::OFF_SRC_SIZE, 32'h0000_0008);
    wr(dcr_pkg::OFF_CTRL, 32'h0000_0001);
    run(8'h01, 1'b1);
    chk({31'h0, dst_half_full_flag}, 32'h0000_0000);
    run(8'h01, 1'b1);
    chk({31'h0, dst_half_full_flag}, 32'h0000_0001);
    rd(dcr_pkg::OFF_INT_STAT, 32'h0000_0010);
    wr(dcr_pkg::OFF_INT_CLR, 32'h0000_0010);
    $display("half full done");
    // A match counts only in pattern mode
    match();
    chk({31'h0, block_done_flag}, 32'h0000_0000);
    rd(dcr_pkg::OFF_SRC_PTR, 32'h0000_0002);
    wr(dcr_pkg::OFF_CTRL, 32'h0000_0003);
    match();
    rd(dcr_pkg::OFF_SRC_PTR, 32'h0000_0000);
    chk({31'h0, block_done_flag}, 32'h0000_0001);
    rd(dcr_pkg::OFF_DST_PTR, 32'h0000_0000);
    chk({31'h0, pattern_mode}, 32'h0000_0001);
    chk({31'h0, chan_enable}, 32'h0000_0000);
    // Strobes while the channel is stopped are ignored
    run(8'h02, 1'b0);
    rd(dcr_pkg::OFF_SRC_PTR, 32'h0000_0000);
    chk({16'h0, dst_size_bytes}, 32'h0000_0004);
    $display("pattern done");
    end_sim();
  end
endmodule
`default_nettype wire

/* test/dcr_engine_model.sv */
// Transfer engine stand-in: byte strobes and pattern events on command.
// Assumes the bench drives its command inputs just after pclk edges.
`timescale 1ns/100ps
`default_nettype none
module dcr_engine_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Commands from the bench
  input wire logic go,
  input wire logic [7:0] n_bytes,
  input wire logic slow,
  input wire logic match_go,
  // Engine strobes
  output logic src_byte_rd,
  output logic dst_byte_wr,
  output logic pattern_match,
  output logic busy
);
  logic [7:0] cnt;
  logic ph;
  assign busy = (cnt != 8'h00);
  // One byte per strobe; slow mode leaves a gap to stretch the block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      ph <= 1'b0;
      src_byte_rd <= 1'b0;
      dst_byte_wr <= 1'b0;
      pattern_match <= 1'b0;
    end else begin
      ph <= ~ph;
      pattern_match <= match_go;
      if (go) begin
        cnt <= n_bytes;
      end else if (busy && (!slow || ph)) begin
        cnt <= cnt - 8'h01;
        src_byte_rd <= 1'b1;
        dst_byte_wr <= 1'b1;
      end else begin
        src_byte_rd <= 1'b0;
        dst_byte_wr <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire
